// >>> rtl/hpc_pkg.sv
// Package for the hub port/power configuration register bank.
// Assumes a byte-wide register port driven by the configuration loader.
package hpc_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] HPC_OFS_CONFIG_BYTE_TWO = 8'h08;
  localparam logic [7:0] HPC_OFS_FIXED_PORT = 8'h09;
  localparam logic [7:0] HPC_OFS_OFF_SELF = 8'h0A;
  localparam logic [7:0] HPC_OFS_OFF_BUS = 8'h0B;
  localparam logic [7:0] HPC_OFS_LIMIT_SELF = 8'h0C;
  localparam logic [7:0] HPC_OFS_LIMIT_BUS = 8'h0D;
  localparam int HPC_NUM_REGS = 6;

  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int HPC_BIT_AUTO_SWITCH = 7;
  localparam int HPC_BIT_DELAY_HI = 5;
  localparam int HPC_BIT_DELAY_LO = 4;
  localparam int HPC_BIT_COMPOUND = 3;
  localparam logic [7:0] HPC_CFG2_MASK = 8'hB8;
  localparam logic [7:0] HPC_PORT_MASK = 8'h1E;
  localparam logic [7:0] HPC_RESET_VAL = 8'h00;
  localparam logic [7:0] HPC_READ_UNMAPPED = 8'h00;

  // ----------------------------------------
  // Over-current delay in ns and cycles at 8 ns
  // ----------------------------------------
  localparam int HPC_CLK_NS = 8;
  localparam int HPC_DELAY0_NS = 100000;
  localparam int HPC_DELAY1_NS = 2000000;
  localparam int HPC_DELAY2_NS = 4000000;
  localparam int HPC_DELAY3_NS = 6000000;
  localparam int HPC_DELAY0_CYC = HPC_DELAY0_NS / HPC_CLK_NS;
  localparam int HPC_DELAY1_CYC = HPC_DELAY1_NS / HPC_CLK_NS;
  localparam int HPC_DELAY2_CYC = HPC_DELAY2_NS / HPC_CLK_NS;
  localparam int HPC_DELAY3_CYC = HPC_DELAY3_NS / HPC_CLK_NS;
  localparam int HPC_DELAY_W = 20;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    HPC_DLY_0P1MS,
    HPC_DLY_2MS,
    HPC_DLY_4MS,
    HPC_DLY_6MS
  } hpc_delay_sel_t;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hpc_reg_req_t;

  typedef struct packed {
    logic self_powered;
    logic compound;
    logic [3:0] port_off;
    logic [3:0] port_fixed;
    logic [7:0] current_limit;
    logic [HPC_DELAY_W-1:0] overcurrent_delay_cycles;
  } hpc_status_t;

endpackage

// >>> rtl/hpc_reg_store.sv
// Small register store for the six configuration bytes.
// Assumes the caller masks reserved bits before writing.
`timescale 1ns/100ps
module hpc_reg_store #(
  parameter int DEPTH = 6,
  parameter int AW = 3
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Write side
  input wire logic wr_en_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [7:0] wdata_in,
  // Read side
  input wire logic [AW-1:0] raddr_in,
  output logic [7:0] rdata_out,
  // All bytes, flat
  output logic [DEPTH*8-1:0] all_out
);
  import hpc_pkg::*;

  logic [7:0] mem_r [DEPTH];

  // ----------------------------------------
  // Storage, one byte per entry
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_byte
      always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
          mem_r[gi] <= HPC_RESET_VAL;
        end else if (wr_en_in && waddr_in == AW'(gi)) begin
          mem_r[gi] <= wdata_in;
        end
      end
      assign all_out[gi*8 +: 8] = mem_r[gi];
    end
  endgenerate

  // Registered read data
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      rdata_out <= HPC_RESET_VAL;
    end else if (int'(raddr_in) < DEPTH) begin
      rdata_out <= mem_r[raddr_in];
    end else begin
      rdata_out <= HPC_READ_UNMAPPED;
    end
  end

endmodule

// >>> rtl/hpc_config_regs.sv
// Hub port and power configuration register bank, bytes 08h..0Dh.
// Assumes a byte-wide register port from the serial loader, synchronous
// to clock_in; the local supply sense pin is already synchronised.
//
// Behaviour
// [RL1] With the auto-switch bit set, mode follows the local supply.
// [RL2] While auto-switching, the stored power select bit is ignored.
// [RL3] Bits 5:4 pick an over-current delay of 0.1, 2, 4 or 6 ms.
// [RL4] Bit 3 set reports the hub as part of a compound device.
// [RL5] Bits 4:1 flag ports 4..1 as non-removable; bit 0 reads zero.
// [RL6] When self-powered, set bits of the self mask disable ports.
// [RL7] When bus-powered, set bits of the bus mask disable ports.
// [RL8] The self-powered limit byte counts current in 2 mA steps.
// [RL9] The bus-powered limit byte is reported when bus-powered.
// [RL10] Software folds a zero-current embedded device into the limits.
// [RL11] Software keeps the self-powered limit at or below 100 mA.
// [RL12] Software writes zeros to reserved bits.
// [RL13] Mask and limit follow the active mode as it changes.
`timescale 1ns/100ps
module hpc_config_regs (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Register port
  input wire hpc_pkg::hpc_reg_req_t req_in,
  output logic [7:0] rdata_out,
  output logic rvalid_out,
  // Power inputs
  input wire logic power_source_select_in,
  input wire logic local_supply_sense_pin_in,
  // Derived configuration
  output hpc_pkg::hpc_status_t status_out,
  output hpc_pkg::hpc_delay_sel_t overcurrent_delay_sel_out
);
  import hpc_pkg::*;

  localparam int AW = 3;

  logic [HPC_NUM_REGS*8-1:0] all_bytes;
  logic [7:0] store_rdata;
  logic [7:0] wmask;
  logic wr_hit;
  logic [AW-1:0] widx;
  logic [AW-1:0] ridx;
  logic [7:0] cfg2;
  logic [7:0] fixed_b;
  logic [7:0] off_self;
  logic [7:0] off_bus;
  logic [7:0] lim_self;
  logic [7:0] lim_bus;
  logic rd_hit;
  logic local_supply_sense_pin_nxt;
  logic [HPC_DELAY_W-1:0] delay_nxt;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  always_comb begin
    wr_hit = req_in.wr_en && req_in.addr >= HPC_OFS_CONFIG_BYTE_TWO &&
      req_in.addr <= HPC_OFS_LIMIT_BUS;
    rd_hit = req_in.addr >= HPC_OFS_CONFIG_BYTE_TWO &&
      req_in.addr <= HPC_OFS_LIMIT_BUS;
    widx = AW'(req_in.addr - HPC_OFS_CONFIG_BYTE_TWO);
    // Idle or unmapped cycles point the store past its last slot, which reads zero
    ridx = (rd_hit && req_in.rd_en) ? widx : AW'(HPC_NUM_REGS);
    case (req_in.addr)
      HPC_OFS_CONFIG_BYTE_TWO: wmask = HPC_CFG2_MASK;
      HPC_OFS_FIXED_PORT: wmask = HPC_PORT_MASK; // RL5
      HPC_OFS_OFF_SELF: wmask = HPC_PORT_MASK; // RL6
      HPC_OFS_OFF_BUS: wmask = HPC_PORT_MASK; // RL7
      default: wmask = 8'hFF;
    endcase
  end

  // Reserved bits dropped on write so they always read zero
  hpc_reg_store #(
    .DEPTH(HPC_NUM_REGS),
    .AW(AW)
  ) u_store (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .wr_en_in(wr_hit),
    .waddr_in(widx),
    .wdata_in(req_in.wdata & wmask),
    .raddr_in(ridx),
    .rdata_out(store_rdata),
    .all_out(all_bytes)
  );

  assign cfg2 = all_bytes[0*8 +: 8];
  assign fixed_b = all_bytes[1*8 +: 8];
  assign off_self = all_bytes[2*8 +: 8];
  assign off_bus = all_bytes[3*8 +: 8];
  assign lim_self = all_bytes[4*8 +: 8];
  assign lim_bus = all_bytes[5*8 +: 8];

  // ----------------------------------------
  // Read return, one cycle after request
  // ----------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      rvalid_out <= 1'b0;
    end else begin
      rvalid_out <= req_in.rd_en;
    end
  end

  // Straight from the store flop; no mux after it keeps the path short
  assign rdata_out = store_rdata;

  // ----------------------------------------
  // Power mode and derived outputs
  // ----------------------------------------
  always_comb begin
    if (cfg2[HPC_BIT_AUTO_SWITCH]) begin
      local_supply_sense_pin_nxt = local_supply_sense_pin_in; // RL1 RL2
    end else begin
      local_supply_sense_pin_nxt = power_source_select_in;
    end
    case (cfg2[HPC_BIT_DELAY_HI:HPC_BIT_DELAY_LO]) // RL3
      2'b00: delay_nxt = HPC_DELAY_W'(HPC_DELAY0_CYC);
      2'b01: delay_nxt = HPC_DELAY_W'(HPC_DELAY1_CYC);
      2'b10: delay_nxt = HPC_DELAY_W'(HPC_DELAY2_CYC);
      default: delay_nxt = HPC_DELAY_W'(HPC_DELAY3_CYC);
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      status_out <= '0;
      overcurrent_delay_sel_out <= HPC_DLY_0P1MS;
    end else begin
      status_out.self_powered <= local_supply_sense_pin_nxt;
      status_out.compound <= cfg2[HPC_BIT_COMPOUND]; // RL4
      status_out.port_fixed <= fixed_b[4:1]; // RL5
      status_out.overcurrent_delay_cycles <= delay_nxt;
      overcurrent_delay_sel_out <=
        hpc_delay_sel_t'(cfg2[HPC_BIT_DELAY_HI:HPC_BIT_DELAY_LO]);
      if (local_supply_sense_pin_nxt) begin
        status_out.port_off <= off_self[4:1]; // RL6 RL13
        status_out.current_limit <= lim_self; // RL8 RL13
      end else begin
        status_out.port_off <= off_bus[4:1]; // RL7 RL13
        status_out.current_limit <= lim_bus; // RL9 RL13
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_auto_follow_pin: assert property (@(posedge clock_in) // RL1
    disable iff (!rst_n_in)
    $past(cfg2[HPC_BIT_AUTO_SWITCH]) && $past(rst_n_in) |->
      status_out.self_powered == $past(local_supply_sense_pin_in))
    else $error("mode does not follow supply sense");

  a_select_ignored: assert property (@(posedge clock_in) // RL2
    disable iff (!rst_n_in)
    $past(cfg2[HPC_BIT_AUTO_SWITCH]) && $past(rst_n_in) &&
      $past(power_source_select_in) != $past(local_supply_sense_pin_in)
      |-> status_out.self_powered != $past(power_source_select_in))
    else $error("select bit used while auto switching");

  a_delay_map: assert property (@(posedge clock_in) // RL3
    disable iff (!rst_n_in)
    $past(rst_n_in) && $past(cfg2[5:4]) == 2'b00 |->
      status_out.overcurrent_delay_cycles == HPC_DELAY_W'(12500))
    else $error("0.1 ms delay count wrong");

  a_compound_flag: assert property (@(posedge clock_in) // RL4
    disable iff (!rst_n_in)
    $past(rst_n_in) |-> status_out.compound == $past(cfg2[3]))
    else $error("compound flag mismatch");

  a_fixed_bit0: assert property (@(posedge clock_in) // RL5
    disable iff (!rst_n_in)
    fixed_b[0] == 1'b0 && off_bus[0] == 1'b0 && off_self[0] == 1'b0)
    else $error("reserved bit 0 set");

  a_self_mask: assert property (@(posedge clock_in) // RL6
    disable iff (!rst_n_in)
    $past(rst_n_in) && $past(local_supply_sense_pin_nxt) |->
      status_out.port_off == $past(off_self[4:1]))
    else $error("self mask not applied");

  a_bus_mask: assert property (@(posedge clock_in) // RL7
    disable iff (!rst_n_in)
    $past(rst_n_in) && !$past(local_supply_sense_pin_nxt) |->
      status_out.port_off == $past(off_bus[4:1]))
    else $error("bus mask not applied");

  a_limit_pick: assert property (@(posedge clock_in) // RL9
    disable iff (!rst_n_in)
    $past(rst_n_in) |-> status_out.current_limit ==
      ($past(local_supply_sense_pin_nxt) ? $past(lim_self) : $past(lim_bus)))
    else $error("wrong current limit reported");

  a_limit_self: assert property (@(posedge clock_in) // RL8
    disable iff (!rst_n_in)
    $past(rst_n_in) && $past(local_supply_sense_pin_nxt) |->
      status_out.current_limit == $past(lim_self))
    else $error("self-powered limit not reported");

  a_manual_mode: assert property (@(posedge clock_in) // RL1
    disable iff (!rst_n_in)
    $past(rst_n_in) && !$past(cfg2[HPC_BIT_AUTO_SWITCH]) |->
      status_out.self_powered == $past(power_source_select_in))
    else $error("mode switched without auto enable");

  a_delay_max: assert property (@(posedge clock_in) // RL3
    disable iff (!rst_n_in)
    $past(rst_n_in) && $past(cfg2[5:4]) == 2'b11 |->
      status_out.overcurrent_delay_cycles == HPC_DELAY_W'(750000))
    else $error("6 ms delay count wrong");

  a_delay_code: assert property (@(posedge clock_in) // RL3
    disable iff (!rst_n_in)
    $past(rst_n_in) |->
      overcurrent_delay_sel_out == hpc_delay_sel_t'($past(cfg2[5:4])))
    else $error("delay code mismatch");

  a_fixed_flags: assert property (@(posedge clock_in) // RL5
    disable iff (!rst_n_in)
    $past(rst_n_in) |-> status_out.port_fixed == $past(fixed_b[4:1]))
    else $error("non-removable flags mismatch");

  a_read_bit0: assert property (@(posedge clock_in) // RL5
    disable iff (!rst_n_in)
    $past(rst_n_in) && $past(req_in.rd_en) &&
      $past(req_in.addr) == HPC_OFS_FIXED_PORT |-> rdata_out[0] == 1'b0)
    else $error("reserved bit 0 read as one");

endmodule

// >>> test/hpc_loader_model.sv
// Model of the configuring party: byte writes and reads on the register port.
// Assumes the bench calls its tasks; requests launch on the falling edge.
`timescale 1ns/100ps
module hpc_loader_model (
  // Clock
  input wire logic clock_in,
  // Register port
  output hpc_pkg::hpc_reg_req_t req_out,
  input wire logic [7:0] rdata_in,
  input wire logic rvalid_in
);
  import hpc_pkg::*;

  initial req_out = '0;

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  // Clean writes obey the loader's duties; raw ones probe the refusals
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d,
    input bit clean);
    logic [7:0] v;
    v = d;
    if (clean) begin
      if (a == HPC_OFS_CONFIG_BYTE_TWO) v = v & HPC_CFG2_MASK;
      else if (a inside {[8'h09:8'h0B]}) v = v & HPC_PORT_MASK;
      else if (a == HPC_OFS_LIMIT_SELF && v > 8'h32) v = 8'h32;
    end
    @(negedge clock_in);
    req_out <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: v};
    @(negedge clock_in);
    // Released lines flip so a stale value never looks valid
    req_out <= '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: ~v};
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
    output logic vld);
    @(negedge clock_in);
    req_out <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clock_in);
    d = rdata_in;
    vld = rvalid_in;
    req_out <= '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: 8'hFF};
  endtask
endmodule

// >>> test/hub_port_power_config_regs_test.sv
// Self-checking bench for the port/power configuration register bank.
// Assumes the loader model drives the register port; pins come from here.
`timescale 1ns/100ps
module hub_port_power_config_regs_test;
  import hpc_pkg::*;

  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic sel_pin = 1'b1;
  logic sense_pin = 1'b0;
  hpc_reg_req_t req;
  logic [7:0] rdata;
  logic rvalid;
  hpc_status_t status;
  hpc_delay_sel_t dsel;
  int error_cnt = 0;
  int compares = 0;
  logic [7:0] ofs [6] = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D};
  logic [7:0] raw_exp [6] = '{8'hB8, 8'h1E, 8'h1E, 8'h1E, 8'hFF, 8'hFF};
  int dly_ns [4] = '{100000, 2000000, 4000000, 6000000};
  logic [2:0] modes [4] = '{3'b010, 3'b001, 3'b101, 3'b110};
  logic self_exp;

  always #4 clock_in = ~clock_in;

  hpc_config_regs hpc_config_regs_i (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .req_in(req),
    .rdata_out(rdata),
    .rvalid_out(rvalid),
    .power_source_select_in(sel_pin),
    .local_supply_sense_pin_in(sense_pin),
    .status_out(status),
    .overcurrent_delay_sel_out(dsel)
  );

  hpc_loader_model hpc_loader_model_i (
    .clock_in(clock_in),
    .req_out(req),
    .rdata_in(rdata),
    .rvalid_in(rvalid)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string n, input logic [63:0] e,
    input logic [63:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    hpc_loader_model_i.read_reg(a, d, v);
    chk("rvalid", 32'h1, v);
    chk("rdata", e, d);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d,
    input bit clean);
    hpc_loader_model_i.write_reg(a, d, clean);
  endtask

  task automatic report_and_stop();
    if (error_cnt == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (20) @(negedge clock_in);
    rst_n_in = 1'b1;
    chk("status", 64'h0, 64'(status));
    chk("delay_sel", 32'h0, dsel);
    for (int i = 0; i < 6; i++) rd_chk(ofs[i], 8'h00);
    // Raw all-ones writes: reserved bits must drop
    for (int i = 0; i < 6; i++) begin
      wr(ofs[i], 8'hFF, 1'b0);
      rd_chk(ofs[i], raw_exp[i]);
    end
    wr(8'h0E, 8'hFF, 1'b0);
    rd_chk(8'h0E, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(8'h08, 8'(c << 4), 1'b1);
      repeat (2) @(negedge clock_in);
      chk("delay_sel", c, dsel);
      chk("delay_cyc", dly_ns[c] / 8, status.overcurrent_delay_cycles);
      chk("compound", 32'h0, status.compound);
    end
    wr(8'h08, 8'h08, 1'b1);
    wr(8'h09, 8'h0A, 1'b1);
    repeat (2) @(negedge clock_in);
    chk("compound", 32'h1, status.compound);
    chk("port_fixed", 32'h5, status.port_fixed);
    wr(8'h0A, 8'h06, 1'b1);
    wr(8'h0B, 8'h18, 1'b1);
    wr(8'h0C, 8'h32, 1'b1);
    wr(8'h0D, 8'h64, 1'b1);
    // Mode table: auto enable, select pin, supply sense
    for (int i = 0; i < 4; i++) begin
      wr(8'h08, {modes[i][2], 7'h00}, 1'b1);
      sel_pin = modes[i][1];
      sense_pin = modes[i][0];
      self_exp = modes[i][2] ? modes[i][0] : modes[i][1];
      repeat (2) @(negedge clock_in);
      chk("self_powered", self_exp, status.self_powered);
      chk("port_off", self_exp ? 4'h3 : 4'hC, status.port_off);
      chk("limit", self_exp ? 8'h32 : 8'h64, status.current_limit);
    end
    // Auto mode follows the sense pin both ways
    sense_pin = 1'b1;
    repeat (2) @(negedge clock_in);
    chk("self_powered", 32'h1, status.self_powered);
    chk("limit", 32'h32, status.current_limit);
    sense_pin = 1'b0;
    repeat (2) @(negedge clock_in);
    chk("self_powered", 32'h0, status.self_powered);
    chk("port_off", 32'hC, status.port_off);
    // Mid-run reset clears every byte
    rst_n_in = 1'b0;
    repeat (2) @(negedge clock_in);
    chk("status", 64'h0, 64'(status));
    chk("delay_sel", 32'h0, dsel);
    rst_n_in = 1'b1;
    for (int i = 0; i < 6; i++) rd_chk(ofs[i], 8'h00);
    report_and_stop();
  end

  initial begin
    repeat (5000) @(posedge clock_in);
    error_cnt++;
    report_and_stop();
  end
endmodule
